// >>> serial_rx_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef SERIAL_RX_REGS_SVH
`define SERIAL_RX_REGS_SVH
`define OFF_CTRL 8'h00
`define OFF_PERIOD 8'h04
`define OFF_BIT_COUNT_CONTROL 8'h08
`define OFF_STATUS 8'h0C
`define OFF_RXBUF 8'h10
`define OFF_TIMER 8'h14
`define OFF_PCPSW 8'h18
`define OFF_TCTRL 8'h1C
`define CTRL_INIT 0
`define CTRL_RETURN_RESTORE_STATUS 1
`define CTRL_EXTEN 2
`define BC_UNVERIFIED 7
`define BC_UNDETECTED 6
`define PSW_BANK 4
`define RST_BIT_COUNT_CONTROL 8'hCB
`define RST_PERIOD 8'h29
`define TIMER_ALL_ONES 8'hFF
`define VEC_EXT 12'h003
`define VEC_TIMER 12'h007
`define STACK_BASE 5'h08
`define STACK_TOP 5'h17
`define CLK_PERIOD_NS 4
`define TICK_NS 80000
`endif

// >>> serial_rx_pkg.sv
// types shared by the serial receiver
package serial_rx_pkg;
  typedef enum logic [1:0] {
    TM_STOP = 2'b00,
    TM_TIMER = 2'b01,
    TM_EVENT = 2'b10
  } tmode_t;
endpackage

// >>> timer_interrupt_serial_receiver.sv
// interrupt-timed serial receiver: timer, interrupt logic, edge detector, APB registers
`timescale 1ns/100ps
`include "serial_rx_regs.svh"
module timer_interrupt_serial_receiver #(
  parameter int TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS,
  parameter int BUF_W = 16
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic rxd, // serial receive pin
  input wire logic ext_int_n, // external interrupt pin, active low
  output logic vector_call, // pulse: forced call taken
  output logic [11:0] vector_addr, // target of forced call
  output logic int_locked, // interrupt lockout level
  output serial_rx_pkg::tmode_t timer_mode // current timer mode
);
  import serial_rx_pkg::*;

  logic rxd_s1, rxd_s2, ext_s1, ext_s2;
  logic pol_q, et_prev_q, edge_test;
  logic [31:0] presc_q;
  logic presc_en;
  logic [7:0] cnt_q, period_q, bit_count_control_q, bc_init_q, rxsum_q;
  tmode_t mode_q;
  logic tflag_q, tint_en_q, ext_en_q, locked_q, rdf_q, err_q, rx_act_q, rx_svc_q;
  logic [BUF_W-1:0] shift_q, rxbuf_q;
  logic [11:0] pc_q;
  logic [7:0] psw_q;
  logic [7:0] stack_ram [`STACK_BASE:`STACK_TOP];
  logic tick, ovf, ext_req, tim_req, take_ext, take_tim, take, ret, rx_svc;
  logic wr, rd_setup, init, sw_return_restore_status, mapped;
  logic [4:0] push_lo, pop_lo;
  logic [2:0] sp_dec;
  logic [7:0] half_p;

  // two stages before anything reads the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      ext_s1 <= 1'b1;
      ext_s2 <= 1'b1;
    end else begin
      rxd_s1 <= rxd;
      rxd_s2 <= rxd_s1;
      ext_s1 <= ext_int_n;
      ext_s2 <= ext_s1;
    end
  end

  assign edge_test = ~(rxd_s2 ^ pol_q);

  // apb decode
  assign wr = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;
  assign init = wr && paddr == `OFF_CTRL && pwdata[`CTRL_INIT];
  assign sw_return_restore_status = wr && paddr == `OFF_CTRL && pwdata[`CTRL_RETURN_RESTORE_STATUS] && locked_q;
  always_comb begin
    unique case (paddr)
      `OFF_CTRL, `OFF_PERIOD, `OFF_BIT_COUNT_CONTROL, `OFF_STATUS,
      `OFF_RXBUF, `OFF_TIMER, `OFF_PCPSW, `OFF_TCTRL: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // prescaler: one enable per timer tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 32'h0;
    end else if (mode_q != TM_TIMER || presc_en) begin
      presc_q <= 32'h0;
    end else begin
      presc_q <= presc_q + 32'h1;
    end
  end
  assign presc_en = mode_q == TM_TIMER && presc_q == 32'(TICK_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      et_prev_q <= 1'b1;
    end else begin
      et_prev_q <= edge_test;
    end
  end

  // event mode counts high-to-low edges of the test input
  assign tick = presc_en || (mode_q == TM_EVENT && et_prev_q && !edge_test);
  assign ovf = tick && cnt_q == `TIMER_ALL_ONES;

  // interrupt selection and lockout
  assign ext_req = !ext_s2 && ext_en_q;
  assign tim_req = tflag_q && tint_en_q;
  assign take_ext = !locked_q && ext_req;
  assign take_tim = !locked_q && !ext_req && tim_req;
  assign take = take_ext || take_tim;
  assign rx_svc = take_tim && rx_act_q;
  // hardware service returns one cycle after it acts; software returns the external one
  assign ret = rx_svc_q || sw_return_restore_status;
  assign half_p = {1'b0, period_q[7:1]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tflag_q <= 1'b0;
    end else if (ovf) begin
      tflag_q <= 1'b1;
    end else if (take_tim) begin
      tflag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_q <= 1'b0;
      rx_svc_q <= 1'b0;
      vector_call <= 1'b0;
      vector_addr <= 12'h000;
    end else begin
      rx_svc_q <= rx_svc;
      vector_call <= take;
      if (take) begin
        locked_q <= 1'b1;
        vector_addr <= take_ext ? `VEC_EXT : `VEC_TIMER;
      end else if (ret) begin
        locked_q <= 1'b0;
      end
    end
  end

  assign push_lo = `STACK_BASE + {1'b0, psw_q[2:0], 1'b0};
  assign sp_dec = psw_q[2:0] - 3'h1;
  assign pop_lo = `STACK_BASE + {1'b0, sp_dec, 1'b0};

  // stack lives in ram bytes 8..23, two bytes per level
  always_ff @(posedge pclk) begin
    if (take) begin
      stack_ram[push_lo] <= pc_q[7:0];
      stack_ram[push_lo + 5'h1] <= {psw_q[7:4], pc_q[11:8]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= 12'h000;
      psw_q <= 8'h00;
    end else if (take) begin
      pc_q <= take_ext ? `VEC_EXT : `VEC_TIMER;
      psw_q[2:0] <= psw_q[2:0] + 3'h1;
      psw_q[`PSW_BANK] <= rx_svc ? 1'b1 : psw_q[`PSW_BANK];
    end else if (ret) begin
      pc_q <= {stack_ram[pop_lo + 5'h1][3:0], stack_ram[pop_lo]};
      psw_q <= {stack_ram[pop_lo + 5'h1][7:4], psw_q[3], sp_dec};
    end else if (wr && paddr == `OFF_PCPSW) begin
      pc_q <= pwdata[11:0];
      psw_q <= {pwdata[23:20], psw_q[3:0]};
    end
  end

  // timer counter and mode; receiver service outranks software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      mode_q <= TM_STOP;
    end else if (rx_svc && bit_count_control_q[`BC_UNVERIFIED] && bit_count_control_q[`BC_UNDETECTED]) begin
      cnt_q <= 8'h00 - half_p;
      mode_q <= TM_TIMER;
    end else if (rx_svc && bit_count_control_q[`BC_UNVERIFIED] && rxd_s2) begin
      cnt_q <= `TIMER_ALL_ONES;
      mode_q <= TM_EVENT;
    end else if (rx_svc) begin
      cnt_q <= 8'h00 - period_q;
      mode_q <= TM_TIMER;
    end else if (init) begin
      cnt_q <= `TIMER_ALL_ONES;
      mode_q <= TM_EVENT;
    end else begin
      if (wr && paddr == `OFF_TIMER) begin
        cnt_q <= pwdata[7:0];
      end else if (tick) begin
        cnt_q <= cnt_q + 8'h01;
      end
      if (wr && paddr == `OFF_TCTRL) begin
        mode_q <= tmode_t'(pwdata[1:0] == 2'b11 ? 2'b00 : pwdata[1:0]);
      end
    end
  end

  // receive sequencer driven by the bit-count control byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_count_control_q <= 8'h00;
      rx_act_q <= 1'b0;
      rdf_q <= 1'b0;
      err_q <= 1'b0;
      shift_q <= '0;
      rxbuf_q <= '0;
      pol_q <= 1'b0;
    end else if (init) begin
      pol_q <= 1'b1;
      bit_count_control_q <= bc_init_q;
      rdf_q <= 1'b1;
      err_q <= 1'b0;
      rx_act_q <= 1'b1;
    end else if (rx_svc) begin
      if (bit_count_control_q[`BC_UNVERIFIED]) begin
        if (bit_count_control_q[`BC_UNDETECTED]) begin
          bit_count_control_q[`BC_UNDETECTED] <= 1'b0;
        end else if (!rxd_s2) begin
          bit_count_control_q[`BC_UNVERIFIED] <= 1'b0;
        end else begin
          err_q <= 1'b1;
          bit_count_control_q <= bc_init_q; // rearm for the next start edge
        end
      end else begin
        shift_q <= {rxd_s2, shift_q[BUF_W-1:1]};
        bit_count_control_q[3:0] <= bit_count_control_q[3:0] - 4'h1;
        if (bit_count_control_q[3:0] == 4'h1) begin
          rdf_q <= 1'b0;
          rx_act_q <= 1'b0;
          rxbuf_q <= {rxd_s2, shift_q[BUF_W-1:1]};
        end
      end
    end else if (wr && paddr == `OFF_STATUS) begin
      pol_q <= pwdata[3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tint_en_q <= 1'b0;
      ext_en_q <= 1'b0;
    end else begin
      if (init) begin
        tint_en_q <= 1'b1; // timer interrupt on from init, off once the last bit is taken
      end else if (rx_svc && !bit_count_control_q[`BC_UNVERIFIED] && bit_count_control_q[3:0] == 4'h1) begin
        tint_en_q <= 1'b0;
      end else if (wr && paddr == `OFF_TCTRL) begin
        tint_en_q <= pwdata[2];
      end
      if (wr && paddr == `OFF_CTRL) begin
        ext_en_q <= pwdata[`CTRL_EXTEN];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_q <= `RST_PERIOD;
      bc_init_q <= `RST_BIT_COUNT_CONTROL;
    end else if (wr) begin
      if (paddr == `OFF_PERIOD) begin
        period_q <= pwdata[7:0];
      end
      if (paddr == `OFF_BIT_COUNT_CONTROL) begin
        bc_init_q <= pwdata[7:0];
      end
    end
  end

  // status byte: receive busy, error, lockout, polarity, test input, timer flag
  assign rxsum_q = {2'b00, tflag_q, edge_test, pol_q, locked_q, err_q, rdf_q};

  // zero-wait slave: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= rd_setup;
      pslverr <= rd_setup && !mapped;
      if (rd_setup && !pwrite) begin
        unique case (paddr)
          `OFF_CTRL: prdata <= {29'h0, ext_en_q, 2'b00};
          `OFF_PERIOD: prdata <= {24'h0, period_q};
          `OFF_BIT_COUNT_CONTROL: prdata <= {16'h0, bc_init_q, bit_count_control_q};
          `OFF_STATUS: prdata <= {24'h0, rxsum_q};
          `OFF_RXBUF: prdata <= {{(32-BUF_W){1'b0}}, rxbuf_q};
          `OFF_TIMER: prdata <= {24'h0, cnt_q};
          `OFF_PCPSW: prdata <= {8'h0, psw_q, 4'h0, pc_q};
          `OFF_TCTRL: prdata <= {29'h0, tint_en_q, mode_q};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_locked <= 1'b0;
      timer_mode <= TM_STOP;
    end else begin
      int_locked <= take || (locked_q && !ret);
      timer_mode <= mode_q;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_take_timer;
    take_tim && rx_act_q;
  endsequence
  sequence s_call7;
    vector_call && vector_addr == `VEC_TIMER;
  endsequence

  property p_ovf;
    ovf |=> tflag_q;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow did not set timer flag");

  property p_vec_tim;
    s_take_timer |=> s_call7 ##1 !locked_q;
  endproperty
  a_vec_tim: assert property (p_vec_tim) else $error("timer call or return wrong");

  property p_prio;
    ext_req && tim_req && !locked_q |=> vector_call && vector_addr == `VEC_EXT;
  endproperty
  a_prio: assert property (p_prio) else $error("external request not first");

  property p_lock;
    take && !rx_svc ##1 !sw_return_restore_status |=> locked_q;
  endproperty
  a_lock: assert property (p_lock) else $error("lockout dropped early");

  property p_ret;
    ret |=> !locked_q && psw_q[2:0] == $past(psw_q[2:0]) - 3'h1;
  endproperty
  a_ret: assert property (p_ret) else $error("return did not pop stack");

  property p_init;
    init |=> pol_q && mode_q == TM_EVENT && cnt_q == `TIMER_ALL_ONES && rdf_q;
  endproperty
  a_init: assert property (p_init) else $error("init did not arm receiver");

  property p_half;
    rx_svc && bit_count_control_q[7:6] == 2'b11 |=> cnt_q == 8'h00 - half_p && mode_q == TM_TIMER;
  endproperty
  a_half: assert property (p_half) else $error("half period not loaded");

  property p_err;
    rx_svc && bit_count_control_q[7:6] == 2'b10 && rxd_s2 |=> err_q && bit_count_control_q[7:6] == 2'b11;
  endproperty
  a_err: assert property (p_err) else $error("false start not flagged");

  property p_done;
    rx_svc && !bit_count_control_q[7] && bit_count_control_q[3:0] == 4'h1 |=> !rdf_q && !tint_en_q && !rx_act_q;
  endproperty
  a_done: assert property (p_done) else $error("completion flags wrong");
endmodule

// >>> serial_tx_model.sv
// remote serial transmitter model driving the receive line
`timescale 1ns/100ps
module serial_tx_model #(
  parameter int BIT_CYC = 32
) (
  input wire logic pclk, // bench clock
  output logic rxd // serial line, mark when idle
);
  initial rxd = 1'b1;
  // start bit, then eleven bits lsb first, then back to mark
  task automatic send(input logic [10:0] bits);
    rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge pclk);
    for (int i = 0; i < 11; i++) begin
      rxd <= bits[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask
  // space pulse well under half a bit, so the start check sees mark
  task automatic glitch();
    rxd <= 1'b0;
    repeat (BIT_CYC / 8) @(posedge pclk);
    rxd <= 1'b1;
  endtask
endmodule

// >>> tb_timer_interrupt_serial_receiver.sv
// self-checking bench for the timer interrupt serial receiver
`timescale 1ns/100ps
`include "serial_rx_regs.svh"
module tb_timer_interrupt_serial_receiver;
  import serial_rx_pkg::*;
  localparam int TICKS = 4;
  localparam int P = 8;
  logic pclk, presetn, psel, penable, pwrite, ext_int_n, rxd, vector_call, int_locked, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [11:0] vector_addr;
  tmode_t timer_mode;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [32:0] rd_q[$];
  logic [32:0] mask_q[$];
  logic [11:0] vec_q[$];
  logic [7:0] lf = 8'h3F;
  logic [10:0] frame;

  timer_interrupt_serial_receiver #(.TICK_CYCLES(TICKS)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .ext_int_n(ext_int_n), .vector_call(vector_call),
    .vector_addr(vector_addr), .int_locked(int_locked), .timer_mode(timer_mode));
  serial_tx_model #(.BIT_CYC(P * TICKS)) tx (.pclk(pclk), .rxd(rxd));

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // leading edge keeps an idle cycle, so psel is never assigned twice in one step
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 8) begin
      n++;
      @(posedge pclk);
    end
    if (n == 8) chk(33'h1, 33'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic e, input logic [31:0] exp, input logic [31:0] m);
    rd_q.push_back({e, exp & m});
    mask_q.push_back({1'b1, m});
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic results();
    $display("compared %0d mismatched %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // results are taken off the note queues as they appear
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
      chk({pslverr, prdata} & mask_q.pop_front(), rd_q.pop_front());
    if (vector_call === 1'b1) begin
      if (vec_q.size() == 0) chk(33'h1, 33'h0);
      else chk({21'h0, vector_addr}, {21'h0, vec_q.pop_front()});
    end
  end

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    #200000;
    n_mismatch++;
    results();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_int_n = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFF_PERIOD, 1'b0, 32'h29, 32'hFF);
    rd(8'h08, 1'b0, 32'hCB00, 32'hFF00);
    rd(8'h20, 1'b1, 32'h0, 32'hFFFFFFFF);
    $display("test reset and refusal done");
    // timer stopped here, so flipping polarity cannot count an edge
    wr(`OFF_STATUS, 32'h08);
    rd(`OFF_STATUS, 1'b0, 32'h18, 32'h18);
    wr(`OFF_STATUS, 32'h00);
    rd(`OFF_STATUS, 1'b0, 32'h00, 32'h18);
    $display("test edge detector done");
    wr(`OFF_PERIOD, P);
    wr(`OFF_CTRL, 32'h1);
    rd(`OFF_STATUS, 1'b0, 32'h09, 32'h0B);
    rd(`OFF_TIMER, 1'b0, 32'hFF, 32'hFF);
    rd(8'h08, 1'b0, 32'hCB, 32'hFF);
    chk({31'h0, timer_mode}, {31'h0, TM_EVENT});
    vec_q.push_back(`VEC_TIMER);
    vec_q.push_back(`VEC_TIMER);
    @(posedge pclk);
    tx.glitch();
    repeat (3 * P * TICKS) @(posedge pclk);
    rd(`OFF_STATUS, 1'b0, 32'h03, 32'h03);
    $display("test false start done");
    wr(`OFF_CTRL, 32'h1);
    lf = lfsr(lf);
    frame[7:0] = lf;
    lf = lfsr(lf);
    frame[10:8] = {1'b1, lf[1:0]};
    repeat (13) vec_q.push_back(`VEC_TIMER);
    @(posedge pclk);
    tx.send(frame);
    repeat (2 * P * TICKS) @(posedge pclk);
    rd(`OFF_STATUS, 1'b0, 32'h00, 32'h03);
    rd(`OFF_RXBUF, 1'b0, {16'h0, frame, 5'h0}, 32'hFFE0);
    rd(8'h08, 1'b0, 32'h00, 32'h0F);
    rd(`OFF_TCTRL, 1'b0, 32'h00, 32'h04);
    chk(vec_q.size(), 33'h0);
    $display("test frame done");
    wr(`OFF_CTRL, 32'h4);
    vec_q.push_back(`VEC_EXT);
    ext_int_n <= 1'b0;
    repeat (8) @(posedge pclk);
    ext_int_n <= 1'b1;
    rd(`OFF_STATUS, 1'b0, 32'h04, 32'h04);
    chk({32'h0, int_locked}, 33'h1);
    wr(`OFF_CTRL, 32'h6);
    rd(`OFF_STATUS, 1'b0, 32'h00, 32'h04);
    chk({32'h0, int_locked}, 33'h0);
    repeat (4) @(posedge pclk);
    chk(vec_q.size(), 33'h0);
    $display("test external interrupt done");
    results();
  end
endmodule
